// File: fagm_pkg.sv
// constants, modes and register map of the fan alert and general pin monitor
// Function
// - each speed input result is double buffered, sampled only in every second slot
// - pin one forced low as full speed input gives maximum drive
// - pin zero as alert output asserts when regulated speed cannot be held
// - pin two as alert input raises an alert while pulled low
// - in closed loop the host reads back the drive value in use, except while pin one forces full speed
// - general pins set as outputs take the levels the host writes
// - hardware full speed request overrides every software mode
// - alarm status bit 4 is set while pin two is low and set as alert input
package fagm_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_DAC = 8'h01;
    localparam logic [7:0] REG_PIN_CFG = 8'h02;
    localparam logic [7:0] REG_PIN_OUT = 8'h03;
    localparam logic [7:0] REG_PIN_IN = 8'h04;
    localparam logic [7:0] REG_ALARM_EN = 8'h05;
    localparam logic [7:0] REG_ALARM_STAT = 8'h06;
    localparam logic [7:0] REG_COUNT_TIME = 8'h07;
    localparam logic [7:0] REG_TACH_ZERO = 8'h08;
    localparam logic [7:0] REG_TACH_ONE = 8'h09;
    localparam logic [7:0] REG_TACH_TWO = 8'h0A;
    localparam logic [7:0] REG_TACH_THREE = 8'h0B;
    localparam logic [7:0] REG_DAC_RB = 8'h0C;
    localparam logic [7:0] REG_TARGET = 8'h0D;
    // ---------------------------------------------------------------
    // fields
    // ---------------------------------------------------------------
    localparam int MODE_LSB = 4;
    localparam int MODE_W = 2;
    typedef enum logic [1:0] {
        MODE_FULL_ON = 2'h0,
        MODE_FULL_OFF = 2'h1,
        MODE_CLOSED = 2'h2,
        MODE_OPEN = 2'h3
    } fagm_mode_t;
    localparam int CFG_ALERT_OUT = 0;
    localparam int CFG_FULL_IN = 1;
    localparam int CFG_ALERT_IN = 2;
    localparam int ALM_MAX = 0;
    localparam int ALM_MIN = 1;
    localparam int ALM_TACH = 2;
    localparam int ALM_PIN_ONE = 3;
    localparam int ALM_PIN_TWO = 4;
    localparam int ALM_W = 5;
    localparam int PIN_N = 5;
    localparam int GENERAL_PIN_ZERO = 0;
    localparam int GENERAL_PIN_ONE = 1;
    localparam int GENERAL_PIN_TWO = 2;
    localparam int GENERAL_PIN_THREE = 3;
    localparam int GENERAL_PIN_FOUR = 4;
    localparam int TACH_N = 4;
    localparam int COUNT_TIME_W = 2;
    // ---------------------------------------------------------------
    // reset values and drive levels
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_DAC = 8'h00;
    localparam logic [7:0] RST_PIN_CFG = 8'h00;
    localparam logic [4:0] RST_PIN_OUT = 5'h1F;
    localparam logic [1:0] RST_COUNT_TIME = 2'h2;
    localparam logic [7:0] RST_TARGET = 8'h80;
    localparam logic [7:0] DAC_FULL_ON = 8'h00;
    localparam logic [7:0] DAC_FULL_OFF = 8'hFF;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_COUNT_BASE_NS = 250000000;
    localparam int COUNT_BASE_CYCLES = T_COUNT_BASE_NS / CLK_PERIOD_NS;
endpackage : fagm_pkg

// File: fagm_tach_if.sv
// slot control and result lines between the monitor and one speed channel
`timescale 1ns/1ns
interface fagm_tach_if;
    logic pulse_edge;
    logic count_en;
    logic xfer;
    logic [7:0] count;
    logic ovf;
    modport ctl (output pulse_edge, output count_en, output xfer, input count, input ovf);
    modport chan (input pulse_edge, input count_en, input xfer, output count, output ovf);
endinterface : fagm_tach_if

// File: fagm_tach_chan.sv
// one double buffered speed pulse counter
`timescale 1ns/1ns
module fagm_tach_chan (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // slot control and result
    fagm_tach_if.chan tif
);
    logic [7:0] work_q;
    logic [7:0] work_d;
    logic at_max;

    assign at_max = (work_q == fagm_pkg::COUNT_MAX);
    // saturate instead of wrapping so an overspeed never reads as slow
    assign work_d = tif.xfer ? 8'h00 : ((tif.count_en && tif.pulse_edge && !at_max) ? work_q + 8'h01 : work_q);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            work_q <= 8'h00;
            tif.count <= 8'h00;
            tif.ovf <= 1'b0;
        end else begin
            work_q <= work_d;
            if (tif.xfer) begin
                tif.count <= work_q;
            end
            tif.ovf <= tif.count_en && tif.pulse_edge && at_max;
        end
    end

    a_hold_update: assert property (@(posedge i_clk) disable iff (i_reset)
        tif.xfer |=> tif.count == $past(work_q) && work_q == 8'h00)
        else $error("held count not taken from working count");
    a_hold_stable: assert property (@(posedge i_clk) disable iff (i_reset)
        !tif.xfer |=> $stable(tif.count))
        else $error("held count changed outside a transfer");
endmodule : fagm_tach_chan

// File: fagm_top.sv
// fan alert, full speed override, speed sampling and general pin monitor
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module fagm_top #(
    parameter int unsigned P_COUNT_BASE_CYCLES = fagm_pkg::COUNT_BASE_CYCLES
) (
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    // register port
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // speed pulse inputs, speed_pulse_in_zero to speed_pulse_in_three
    input wire logic [3:0] I_SPEED_PULSE,
    // open drain general pins, general_pin_zero to general_pin_four
    input wire logic [4:0] I_GENERAL_PIN,
    output logic [4:0] O_GENERAL_PIN,
    output logic [4:0] O_GENERAL_PIN_OE,
    // fan drive and interrupt
    output logic [7:0] O_DRIVE_DAC,
    output logic O_IRQ
);
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RESET);

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [4:0] gp_s1_q;
    logic [4:0] gp_s2_q;
    logic [3:0] sp_s1_q;
    logic [3:0] sp_s2_q;
    logic [3:0] sp_s3_q;
    logic [3:0] sp_rise;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            gp_s1_q <= 5'h1F;
            gp_s2_q <= 5'h1F;
            // idle high like a stopped fan, so release gives no false edge
            sp_s1_q <= 4'hF;
            sp_s2_q <= 4'hF;
            sp_s3_q <= 4'hF;
        end else begin
            gp_s1_q <= I_GENERAL_PIN;
            gp_s2_q <= gp_s1_q;
            sp_s1_q <= I_SPEED_PULSE;
            sp_s2_q <= sp_s1_q;
            sp_s3_q <= sp_s2_q;
        end
    end

    assign sp_rise = sp_s2_q & ~sp_s3_q;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] config_q;
    logic [7:0] dac_q;
    logic [7:0] pin_cfg_q;
    logic [4:0] pin_out_q;
    logic [4:0] alarm_en_q;
    logic [4:0] alarm_stat_q;
    logic [4:0] alarm_stat_d;
    logic [1:0] count_time_q;
    logic [7:0] target_q;
    logic [7:0] loop_dac_q;
    logic [7:0] loop_dac_d;

    wire wr_config = I_WR && (I_ADDR == fagm_pkg::REG_CONFIG);
    wire wr_dac = I_WR && (I_ADDR == fagm_pkg::REG_DAC);
    wire wr_pin_cfg = I_WR && (I_ADDR == fagm_pkg::REG_PIN_CFG);
    wire wr_pin_out = I_WR && (I_ADDR == fagm_pkg::REG_PIN_OUT);
    wire wr_alarm_en = I_WR && (I_ADDR == fagm_pkg::REG_ALARM_EN);
    wire wr_alarm_stat = I_WR && (I_ADDR == fagm_pkg::REG_ALARM_STAT);
    wire wr_count_time = I_WR && (I_ADDR == fagm_pkg::REG_COUNT_TIME);
    wire wr_target = I_WR && (I_ADDR == fagm_pkg::REG_TARGET);

    fagm_pkg::fagm_mode_t mode;
    assign mode = fagm_pkg::fagm_mode_t'(config_q[fagm_pkg::MODE_LSB +: fagm_pkg::MODE_W]);

    // ---------------------------------------------------------------
    // count slot timebase
    // ---------------------------------------------------------------
    // each slot lasts one count time; even slots count and move results in their last
    // cycle, odd slots stay idle, so a selector change settles before the next count
    logic [31:0] tb_cnt_q;
    logic phase_q;
    logic upd_q;
    wire [31:0] slot_len = P_COUNT_BASE_CYCLES << count_time_q;
    wire slot_end = (tb_cnt_q >= slot_len - 32'h1);
    wire count_en = !phase_q && !slot_end;
    wire xfer = !phase_q && slot_end;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET || wr_count_time) begin
            tb_cnt_q <= 32'h0;
            phase_q <= 1'b0;
        end else if (slot_end) begin
            tb_cnt_q <= 32'h0;
            phase_q <= !phase_q;
        end else begin
            tb_cnt_q <= tb_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            upd_q <= 1'b0;
        end else begin
            upd_q <= xfer;
        end
    end

    // ---------------------------------------------------------------
    // speed channels
    // ---------------------------------------------------------------
    logic [7:0] ch_count [fagm_pkg::TACH_N];
    logic [3:0] ch_ovf;

    for (genvar i = 0; i < fagm_pkg::TACH_N; i++) begin : g_chan
        fagm_tach_if tif ();
        assign tif.pulse_edge = sp_rise[i];
        assign tif.count_en = count_en;
        assign tif.xfer = xfer;
        assign ch_count[i] = tif.count;
        assign ch_ovf[i] = tif.ovf;
        fagm_tach_chan u_chan (
            .i_clk(I_CORE_CLK),
            .i_reset(I_RESET),
            .tif(tif.chan)
        );
    end

    // ---------------------------------------------------------------
    // closed loop drive
    // ---------------------------------------------------------------
    // a low drive value means more voltage across the fan, so a slow fan
    // steps the value down; one step per result keeps the loop slow
    wire closed = (mode == fagm_pkg::MODE_CLOSED);
    wire too_slow = ch_count[0] < target_q;
    wire too_fast = ch_count[0] > target_q;
    wire at_full = (loop_dac_q == fagm_pkg::DAC_FULL_ON);
    wire at_off = (loop_dac_q == fagm_pkg::DAC_FULL_OFF);

    always_comb begin
        loop_dac_d = loop_dac_q;
        if (upd_q && closed && too_slow && !at_full) begin
            loop_dac_d = loop_dac_q - 8'h01;
        end else if (upd_q && closed && too_fast && !at_off) begin
            loop_dac_d = loop_dac_q + 8'h01;
        end
    end

    // ---------------------------------------------------------------
    // drive selection
    // ---------------------------------------------------------------
    wire force_full = pin_cfg_q[fagm_pkg::CFG_FULL_IN] && !gp_s2_q[fagm_pkg::GENERAL_PIN_ONE];
    logic [7:0] drive_d;

    always_comb begin
        drive_d = fagm_pkg::DAC_FULL_ON;
        if (force_full) begin
            drive_d = fagm_pkg::DAC_FULL_ON;
        end else begin
            case (mode)
                fagm_pkg::MODE_FULL_ON: drive_d = fagm_pkg::DAC_FULL_ON;
                fagm_pkg::MODE_FULL_OFF: drive_d = fagm_pkg::DAC_FULL_OFF;
                fagm_pkg::MODE_OPEN: drive_d = dac_q;
                fagm_pkg::MODE_CLOSED: drive_d = loop_dac_q;
                default: drive_d = fagm_pkg::DAC_FULL_ON;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // alarms
    // ---------------------------------------------------------------
    logic [4:0] alarm_ev;
    assign alarm_ev[fagm_pkg::ALM_MAX] = upd_q && closed && too_slow && at_full;
    assign alarm_ev[fagm_pkg::ALM_MIN] = upd_q && closed && too_fast && at_off;
    assign alarm_ev[fagm_pkg::ALM_TACH] = |ch_ovf;
    assign alarm_ev[fagm_pkg::ALM_PIN_ONE] = force_full;
    assign alarm_ev[fagm_pkg::ALM_PIN_TWO] = pin_cfg_q[fagm_pkg::CFG_ALERT_IN] &&
        !gp_s2_q[fagm_pkg::GENERAL_PIN_TWO];

    wire [4:0] alarm_clr = wr_alarm_stat ? I_WDATA[4:0] : 5'h00;
    // a new event beats a clear in the same cycle
    assign alarm_stat_d = (alarm_stat_q & ~alarm_clr) | alarm_ev;
    wire alert_active = |(alarm_stat_q & alarm_en_q);

    // ---------------------------------------------------------------
    // general pin drive
    // ---------------------------------------------------------------
    // open drain: enable high pulls the pin low, a written one releases it
    logic [4:0] pin_oe_d;
    assign pin_oe_d[0] = pin_cfg_q[fagm_pkg::CFG_ALERT_OUT] ? alert_active : !pin_out_q[0];
    assign pin_oe_d[1] = pin_cfg_q[fagm_pkg::CFG_FULL_IN] ? 1'b0 : !pin_out_q[1];
    assign pin_oe_d[2] = pin_cfg_q[fagm_pkg::CFG_ALERT_IN] ? 1'b0 : !pin_out_q[2];
    assign pin_oe_d[4:3] = ~pin_out_q[4:3];

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (I_ADDR)
            fagm_pkg::REG_CONFIG: rd_mux = config_q;
            fagm_pkg::REG_DAC: rd_mux = dac_q;
            fagm_pkg::REG_PIN_CFG: rd_mux = pin_cfg_q;
            fagm_pkg::REG_PIN_OUT: rd_mux = {3'h0, pin_out_q};
            fagm_pkg::REG_PIN_IN: rd_mux = {3'h0, gp_s2_q};
            fagm_pkg::REG_ALARM_EN: rd_mux = {3'h0, alarm_en_q};
            fagm_pkg::REG_ALARM_STAT: rd_mux = {3'h0, alarm_stat_q};
            fagm_pkg::REG_COUNT_TIME: rd_mux = {6'h00, count_time_q};
            fagm_pkg::REG_TACH_ZERO: rd_mux = ch_count[0];
            fagm_pkg::REG_TACH_ONE: rd_mux = ch_count[1];
            fagm_pkg::REG_TACH_TWO: rd_mux = ch_count[2];
            fagm_pkg::REG_TACH_THREE: rd_mux = ch_count[3];
            fagm_pkg::REG_DAC_RB: rd_mux = loop_dac_q;
            fagm_pkg::REG_TARGET: rd_mux = target_q;
            default: rd_mux = 8'h00;
        endcase
    end
    wire [7:0] rdata_d = I_RD ? rd_mux : 8'h00;

    // ---------------------------------------------------------------
    // state update
    // ---------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            config_q <= fagm_pkg::RST_CONFIG;
            dac_q <= fagm_pkg::RST_DAC;
            pin_cfg_q <= fagm_pkg::RST_PIN_CFG;
            pin_out_q <= fagm_pkg::RST_PIN_OUT;
            count_time_q <= fagm_pkg::RST_COUNT_TIME;
            target_q <= fagm_pkg::RST_TARGET;
            alarm_en_q <= 5'h00;
        end else begin
            if (wr_config) config_q <= I_WDATA;
            if (wr_dac) dac_q <= I_WDATA;
            if (wr_pin_cfg) pin_cfg_q <= {5'h00, I_WDATA[2:0]};
            if (wr_pin_out) pin_out_q <= I_WDATA[4:0];
            if (wr_count_time) count_time_q <= I_WDATA[1:0];
            if (wr_target) target_q <= I_WDATA;
            if (wr_alarm_en) alarm_en_q <= I_WDATA[4:0];
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            alarm_stat_q <= 5'h00;
            loop_dac_q <= fagm_pkg::DAC_FULL_ON;
            O_DRIVE_DAC <= fagm_pkg::DAC_FULL_ON;
            O_GENERAL_PIN <= 5'h00;
            O_GENERAL_PIN_OE <= 5'h00;
            O_IRQ <= 1'b0;
            O_RDATA <= 8'h00;
        end else begin
            alarm_stat_q <= alarm_stat_d;
            loop_dac_q <= loop_dac_d;
            O_DRIVE_DAC <= drive_d;
            O_GENERAL_PIN <= 5'h00;
            O_GENERAL_PIN_OE <= pin_oe_d;
            O_IRQ <= alert_active;
            O_RDATA <= rdata_d;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_slot_alternate: assert property (xfer && !wr_count_time |-> !count_en ##1 !count_en)
        else $error("counting seen in a transfer slot");
    a_force_full: assert property (force_full |=> O_DRIVE_DAC == fagm_pkg::DAC_FULL_ON)
        else $error("forced full speed did not give maximum drive");
    a_force_override: assert property ((force_full && mode == fagm_pkg::MODE_FULL_OFF) ##1
        force_full |-> O_DRIVE_DAC != fagm_pkg::DAC_FULL_OFF)
        else $error("software mode beat the hardware override");
    a_cant_hold: assert property (alarm_ev[fagm_pkg::ALM_MAX] && pin_cfg_q[fagm_pkg::CFG_ALERT_OUT] &&
        alarm_en_q[fagm_pkg::ALM_MAX] && !wr_pin_cfg && !wr_alarm_en |=> ##1 O_GENERAL_PIN_OE[0])
        else $error("alert pin not driven after loss of regulation");
    a_pin_two_alert: assert property (alarm_ev[fagm_pkg::ALM_PIN_TWO] |=>
        alarm_stat_q[fagm_pkg::ALM_PIN_TWO])
        else $error("pin two low did not set its alarm");
    a_readback_dac: assert property (I_RD && I_ADDR == fagm_pkg::REG_DAC_RB |=>
        O_RDATA == $past(loop_dac_q))
        else $error("drive readback differs from loop value");
    a_plain_output: assert property (1'b1 |=>
        O_GENERAL_PIN_OE[4:3] == ~$past(pin_out_q[4:3]))
        else $error("plain output level not followed");
    a_alert_masked: assert property (pin_cfg_q[fagm_pkg::CFG_ALERT_OUT] &&
        (alarm_stat_q & alarm_en_q) == 5'h00 |=> !O_GENERAL_PIN_OE[0] && !O_IRQ)
        else $error("disabled alarm reached the alert pin");
    a_set_wins: assert property (wr_alarm_stat && (I_WDATA[4:0] & alarm_ev) != 5'h00 |=>
        (alarm_stat_q & $past(alarm_ev)) == $past(alarm_ev))
        else $error("clear dropped an event in the same cycle");
endmodule : fagm_top

// File: fagm_fan_model.sv
// far side model: spinning fans, one fan behind a selector, pulled-up general pins
`timescale 1ns/1ns
module fagm_fan_model (
    // pin pulls from the device and the bench, fan power
    input wire logic [4:0] i_oe,
    input wire logic [4:0] i_ext_low,
    input wire logic [3:0] i_run,
    // lines into the device
    output logic [3:0] o_pulse,
    output logic [4:0] o_pin
);
    logic tach_q = 1'b0;
    logic sel_live;
    logic [3:0] spin;
    // free running tach, phase unrelated to the core clock
    initial begin
        #137;
        forever #400 tach_q = ~tach_q;
    end
    // open drain with pull-up: any party pulling low wins
    assign o_pin = ~(i_oe | i_ext_low);
    // selector address zero parks the fan behind it
    assign sel_live = |o_pin[4:2];
    assign spin = {i_run[3] & sel_live, i_run[2:0]};
    // a stopped fan leaves its tach line at the pull-up level
    assign o_pulse = ~spin | {4{tach_q}};
endmodule : fagm_fan_model

// File: fagm_top_bench.sv
// self-checking bench for the fan alert and general pin monitor
`timescale 1ns/1ns
module fagm_top_bench;
    localparam int unsigned BASE = 64;
    logic core_clk;
    logic reset;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic [3:0] pulse;
    logic [4:0] pin;
    logic [4:0] pin_out;
    logic [4:0] pin_oe;
    logic [7:0] drive;
    logic irq;
    logic [4:0] ext_low;
    logic [3:0] run;
    logic [7:0] val;
    logic [7:0] free_drive [4] = '{8'h00, 8'hFF, 8'h00, 8'h55};
    int errors;
    int n_checks;

    fagm_top #(.P_COUNT_BASE_CYCLES(BASE)) DUT (
        .I_CORE_CLK(core_clk), .I_RESET(reset), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SPEED_PULSE(pulse),
        .I_GENERAL_PIN(pin), .O_GENERAL_PIN(pin_out), .O_GENERAL_PIN_OE(pin_oe),
        .O_DRIVE_DAC(drive), .O_IRQ(irq)
    );
    fagm_fan_model u_fans (.i_oe(pin_oe), .i_ext_low(ext_low), .i_run(run), .o_pulse(pulse), .o_pin(pin));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ---------------------------------------------------------------
    // register port and compares
    // ---------------------------------------------------------------
    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cycles
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk_in(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        n_checks++;
        if (!(got >= lo && got <= hi) || $isunknown(got)) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h outside %h..%h", $time, got, lo, hi);
        end
    endtask : chk_in
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        reg_rd(a, d);
        chk8(d, exp);
    endtask : reg_chk
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // a hung loop wait must still end the run
    initial begin
        #(100 * 90000);
        errors++;
        complete_run();
    end

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        reset = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        ext_low = 5'h00;
        run = 4'hF;
        errors = 0;
        n_checks = 0;
        cycles(8);
        reset <= 1'b0;
        reg_chk(fagm_pkg::REG_CONFIG, fagm_pkg::RST_CONFIG);
        reg_chk(fagm_pkg::REG_PIN_OUT, {3'h0, fagm_pkg::RST_PIN_OUT});
        reg_chk(fagm_pkg::REG_COUNT_TIME, {6'h00, fagm_pkg::RST_COUNT_TIME});
        reg_chk(fagm_pkg::REG_TARGET, fagm_pkg::RST_TARGET);
        reg_chk(8'h20, 8'h00);
        // plain outputs: a written zero pulls the pin low
        reg_wr(fagm_pkg::REG_PIN_OUT, 8'h15);
        cycles(4);
        chk8({3'h0, pin_oe}, 8'h0A);
        chk8({3'h0, pin_out}, 8'h00);
        reg_chk(fagm_pkg::REG_PIN_IN, 8'h15);
        reg_wr(fagm_pkg::REG_PIN_OUT, 8'h1F);
        // hardware full speed in every mode, then the mode's own drive back except in closed loop
        reg_wr(fagm_pkg::REG_PIN_CFG, 8'h02);
        reg_wr(fagm_pkg::REG_DAC, 8'h55);
        for (int m = 0; m < 4; m++) begin
            reg_wr(fagm_pkg::REG_CONFIG, 8'(m * 16));
            ext_low[1] <= 1'b1;
            cycles(6);
            chk8(drive, fagm_pkg::DAC_FULL_ON);
            ext_low[1] <= 1'b0;
            cycles(6);
            if (m != 2) chk8(drive, free_drive[m]);
        end
        // alert-in pin: status always, interrupt and alert pin only when enabled
        reg_wr(fagm_pkg::REG_CONFIG, 8'h00);
        reg_wr(fagm_pkg::REG_PIN_CFG, 8'h05);
        reg_wr(fagm_pkg::REG_ALARM_STAT, 8'h1F);
        ext_low[2] <= 1'b1;
        cycles(6);
        reg_chk(fagm_pkg::REG_ALARM_STAT, 8'h10);
        chk8({7'h00, irq}, 8'h00);
        reg_wr(fagm_pkg::REG_ALARM_EN, 8'h10);
        cycles(2);
        chk8({7'h00, irq}, 8'h01);
        chk8({7'h00, pin_oe[0]}, 8'h01);
        ext_low[2] <= 1'b0;
        cycles(6);
        reg_wr(fagm_pkg::REG_ALARM_STAT, 8'h10);
        cycles(2);
        reg_chk(fagm_pkg::REG_ALARM_STAT, 8'h00);
        chk8({7'h00, irq}, 8'h00);
        // selector on the muxed fan, settled before each read
        reg_wr(fagm_pkg::REG_PIN_CFG, 8'h00);
        reg_wr(fagm_pkg::REG_COUNT_TIME, 8'h00);
        reg_wr(fagm_pkg::REG_PIN_OUT, 8'h03);
        cycles(4 * BASE);
        reg_chk(fagm_pkg::REG_TACH_THREE, 8'h00);
        reg_wr(fagm_pkg::REG_PIN_OUT, 8'h1F);
        cycles(4 * BASE);
        reg_rd(fagm_pkg::REG_TACH_THREE, val);
        chk_in(val, 8'h07, 8'h08);
        reg_rd(fagm_pkg::REG_TACH_ZERO, val);
        chk_in(val, 8'h07, 8'h08);
        reg_rd(fagm_pkg::REG_TACH_ONE, val);
        chk_in(val, 8'h07, 8'h08);
        reg_rd(fagm_pkg::REG_TACH_TWO, val);
        chk_in(val, 8'h07, 8'h08);
        // closed loop with a stalled fan: drive bottoms out, alert follows
        run[0] <= 1'b0;
        reg_wr(fagm_pkg::REG_PIN_CFG, 8'h01);
        reg_wr(fagm_pkg::REG_ALARM_EN, 8'h01);
        reg_wr(fagm_pkg::REG_CONFIG, 8'h20);
        for (int i = 0; i < 40000 && irq !== 1'b1; i++) cycles(1);
        cycles(2);
        chk8({7'h00, irq}, 8'h01);
        chk8({7'h00, pin_oe[0]}, 8'h01);
        reg_chk(fagm_pkg::REG_ALARM_STAT, 8'h01);
        reg_chk(fagm_pkg::REG_DAC_RB, fagm_pkg::DAC_FULL_ON);
        chk8(drive, fagm_pkg::DAC_FULL_ON);
        // fan back and faster than target: drive climbs a step per transfer
        run[0] <= 1'b1;
        reg_wr(fagm_pkg::REG_TARGET, 8'h01);
        cycles(8 * BASE);
        reg_wr(fagm_pkg::REG_ALARM_STAT, 8'h01);
        cycles(2);
        chk8({7'h00, irq}, 8'h00);
        reg_rd(fagm_pkg::REG_DAC_RB, val);
        chk_in(val, 8'h01, 8'h04);
        // reset in mid-run: loop value, pins and interrupt back to rest
        cycles(1);
        reset <= 1'b1;
        cycles(3);
        reset <= 1'b0;
        reg_chk(fagm_pkg::REG_DAC_RB, fagm_pkg::DAC_FULL_ON);
        chk8({3'h0, pin_oe}, 8'h00);
        chk8({7'h00, irq}, 8'h00);
        reg_chk(fagm_pkg::REG_ALARM_EN, 8'h00);
        complete_run();
    end
endmodule : fagm_top_bench
